/* core/ppw_core.sv */
/*
  Port pulse and pattern wait engine: long toggle trains on a chosen pin and
  masked pattern waits on an 8-bit port, with optional debouncing.
  Assumes port inputs synchronous to clk (125 MHz) and a host on the register
  port that waits for the done flag before issuing the next command.
*/
`include "ppw_regs.svh"

module ppw_core (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        sys_rst,
  // register port
  input  wire logic [3:0]  regAddr,
  input  wire logic [31:0] regWdata,
  input  wire logic        regWrite,
  input  wire logic        regRead,
  output logic      [31:0] regRdata,
  // port pins
  input  wire logic [7:0]  portIn,
  output logic      [7:0]  pinOut,
  // command state
  output logic             cmdBusy,
  output logic             cmdDone
);

  // entries held minus one so 65536 fits sixteen bits
  function automatic logic [15:0] clampDelay(input logic [31:0] val);
    logic [31:0] lim;
    lim = (val > `PPW_MAX_DELAY) ? `PPW_MAX_DELAY : val;
    clampDelay = (lim == 32'h0000_0000) ? 16'h0000 : 16'(lim - 32'h0000_0001);
  endfunction

  // interval in instruction cycles for a stored entry d = delay - 1
  function automatic logic [17:0] intervalTicks(input logic [15:0] d);
    logic [17:0] dl;
    dl = {2'h0, d};
    intervalTicks = `PPW_FIXED_INST + `PPW_INNER_INST * (dl + 18'h0_0001)
                  + `PPW_OUTER_INST * {10'h000, d[15:8]};
  endfunction

  // masked compare of one whole sample
  function automatic logic maskedEqual(input logic [7:0] smp, input logic [7:0] pat,
                                       input logic [7:0] msk);
    maskedEqual = ((smp ^ pat) & msk) == 8'h00;
  endfunction

  ppw_pkg::ppw_state_t state;
  ppw_pkg::ppw_state_t next_state;

  logic [7:0]  mask;
  logic [7:0]  firstPattern;
  logic [7:0]  secondPattern;
  logic [15:0] repeatCount;
  logic [4:0]  intervalCount;
  logic [4:0]  wrIndex;
  logic [2:0]  pinSel;
  logic        isChange;
  logic        isDebounced;
  logic [6:0]  phaseAcc;
  logic        instTick;
  logic [4:0]  entryIdx;
  logic [17:0] elapsed;
  logic [2:0]  passCnt;
  logic [15:0] hits;
  logic        done;
  logic [15:0] memRdata;

  // register decode
  wire         wrCmd      = regWrite && (regAddr == `PPW_ADDR_CMD);
  wire [1:0]   reqKind    = regWdata[`PPW_CMD_KIND_MSB:`PPW_CMD_KIND_LSB];
  wire         idle       = (state == ppw_pkg::PPW_IDLE);
  wire         startCmd   = wrCmd && regWdata[`PPW_CMD_GO] && idle
                          && (reqKind != ppw_pkg::PPW_KIND_UNUSED);
  wire         startLong  = startCmd && (reqKind == ppw_pkg::PPW_KIND_LONG_TRAIN);
  wire         startWait  = startCmd && !startLong;
  // entry writes are refused while busy so a running train never sees them
  wire         wrDelay    = regWrite && (regAddr == `PPW_ADDR_DELAY) && idle
                          && (wrIndex < `PPW_MAX_ENTRIES);

  // instruction tick: 12 per clock modulo 125, exact 12 MHz average
  wire [7:0]   accSum     = {1'b0, phaseAcc} + `PPW_INST_RATE_MHZ;
  wire         accWrap    = accSum >= `PPW_CLK_RATE_MHZ;
  wire [6:0]   next_phase = accWrap ? 7'(accSum - `PPW_CLK_RATE_MHZ) : accSum[6:0];

  // interval length from the stored entry, overhead included
  wire [17:0]  target     = intervalTicks(memRdata);
  wire         trainEdge  = (state == ppw_pkg::PPW_TRAIN) && instTick
                          && (elapsed + 18'h0_0001 >= target);
  wire         lastEntry  = (entryIdx + 5'h01) >= intervalCount;

  // five cycles per pass, six when debounced
  wire [2:0]   passLen    = isDebounced ? `PPW_DEBOUNCE_INST : `PPW_SAMPLE_INST;
  wire         seeking    = (state == ppw_pkg::PPW_SEEK_FIRST)
                          || (state == ppw_pkg::PPW_SEEK_SECOND);
  wire         sample     = seeking && instTick && (passCnt == passLen - 3'h1);
  wire [7:0]   curPattern = (state == ppw_pkg::PPW_SEEK_SECOND) ? secondPattern
                                                                 : firstPattern;
  // masked pins drop out of the compare
  wire         match      = maskedEqual(portIn, curPattern, mask);
  wire [15:0]  needHits   = (repeatCount == 16'h0000) ? 16'h0001 : repeatCount;
  wire [15:0]  hitsInc    = hits + 16'h0001;
  // when debounced, accept only after the programmed run of consecutive matches; otherwise on the first match
  wire         accept     = sample && match && (!isDebounced || hitsInc >= needHits);
  wire         waitDone   = accept && ((state == ppw_pkg::PPW_SEEK_SECOND) || !isChange);
  wire         trainDone  = (trainEdge && lastEntry)
                          || (startLong && (intervalCount == 5'h00));
  wire         doneEvent  = trainDone || waitDone;

  // toggle once at command, once per finished interval
  wire [2:0]   toggleSel  = startLong ? regWdata[`PPW_CMD_PIN_MSB:`PPW_CMD_PIN_LSB]
                                      : pinSel;
  wire         toggleNow  = startLong || trainEdge;
  wire [7:0]   next_pins  = toggleNow ? (pinOut ^ (8'h01 << toggleSel)) : pinOut;

  // clamp the entry count to twenty
  wire [4:0]   countIn    = (regWdata > 32'h0000_0014) ? `PPW_MAX_ENTRIES
                                                       : regWdata[4:0];

  ppw_delay_mem delayMem (
    .clk     (clk),
    .sys_rst (sys_rst),
    .wrEn    (wrDelay),
    .wrAddr  (wrIndex),
    .wrData  (clampDelay(regWdata)),
    .rdAddr  (entryIdx),
    .rdData  (memRdata)
  );

  // next state of the engine
  always_comb begin
    next_state = state;
    case (state)
      ppw_pkg::PPW_IDLE: begin
        if (startLong && intervalCount != 5'h00) begin
          next_state = ppw_pkg::PPW_TRAIN;
        end else if (startWait) begin
          next_state = ppw_pkg::PPW_SEEK_FIRST;
        end
      end
      ppw_pkg::PPW_TRAIN: begin
        if (trainEdge && lastEntry) begin
          next_state = ppw_pkg::PPW_IDLE;
        end
      end
      // no timeout: only an accepted match leaves a seek state
      ppw_pkg::PPW_SEEK_FIRST: begin
        // the second pattern is only looked for after the first
        if (accept) begin
          next_state = isChange ? ppw_pkg::PPW_SEEK_SECOND : ppw_pkg::PPW_IDLE;
        end
      end
      ppw_pkg::PPW_SEEK_SECOND: begin
        // other patterns in between simply keep us here
        if (accept) begin
          next_state = ppw_pkg::PPW_IDLE;
        end
      end
      default: next_state = ppw_pkg::PPW_IDLE;
    endcase
  end

  // engine state and instruction phase
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      state    <= ppw_pkg::PPW_IDLE;
      phaseAcc <= 7'h00;
      instTick <= 1'b0;
    end else begin
      state    <= next_state;
      phaseAcc <= next_phase;
      instTick <= accWrap;
    end
  end

  // configuration written by software, only while idle; command word fields are latched in the block below
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      mask          <= `PPW_RST_MASK;
      firstPattern  <= `PPW_RST_PATTERN;
      secondPattern <= `PPW_RST_PATTERN;
      repeatCount   <= `PPW_RST_REPEAT;
      intervalCount <= `PPW_RST_COUNT;
    end else if (regWrite && idle) begin
      if (regAddr == `PPW_ADDR_MASK)   mask          <= regWdata[7:0];
      if (regAddr == `PPW_ADDR_FIRST)  firstPattern  <= regWdata[7:0];
      if (regAddr == `PPW_ADDR_SECOND) secondPattern <= regWdata[7:0];
      if (regAddr == `PPW_ADDR_REPEAT) repeatCount   <= regWdata[15:0];
      if (regAddr == `PPW_ADDR_COUNT)  intervalCount <= countIn;
    end
  end

  // command fields captured only when the command is accepted
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      pinSel      <= 3'h0;
      isChange    <= 1'b0;
      isDebounced <= 1'b0;
    end else if (startCmd) begin
      pinSel      <= regWdata[`PPW_CMD_PIN_MSB:`PPW_CMD_PIN_LSB];
      isChange    <= reqKind == ppw_pkg::PPW_KIND_AWAIT_CHANGE;
      isDebounced <= regWdata[`PPW_CMD_DEBOUNCE];
    end
  end

  // entry write pointer: set directly, then advances with each entry written
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      wrIndex <= 5'h00;
    end else if (regWrite && idle && regAddr == `PPW_ADDR_INDEX) begin
      wrIndex <= (regWdata > 32'h0000_0013) ? `PPW_MAX_ENTRIES : regWdata[4:0];
    end else if (wrDelay) begin
      wrIndex <= wrIndex + 5'h01;
    end
  end

  // elapsed counts instruction cycles of the running interval
  // the outer-loop share is folded into target by intervalTicks
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      entryIdx <= 5'h00;
      elapsed  <= 18'h0_0000;
    end else if (startLong) begin
      entryIdx <= 5'h00;
      elapsed  <= 18'h0_0000;
    end else if (trainEdge) begin
      entryIdx <= entryIdx + 5'h01;
      elapsed  <= 18'h0_0000;
    end else if (state == ppw_pkg::PPW_TRAIN && instTick) begin
      elapsed  <= elapsed + 18'h0_0001;
    end
  end

  // pass counter spaces reads by the pass length in instruction cycles
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      passCnt <= 3'h0;
    end else if (startWait || sample) begin
      passCnt <= 3'h0;
    end else if (seeking && instTick) begin
      passCnt <= passCnt + 3'h1;
    end
  end

  // a mismatch restarts the run; each step starts fresh
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      hits <= 16'h0000;
    end else if (startWait || accept) begin
      hits <= 16'h0000;
    end else if (sample) begin
      hits <= match ? hitsInc : 16'h0000;
    end
  end

  // done is sticky until the next accepted command; set wins
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      done <= 1'b0;
    end else if (doneEvent) begin
      done <= 1'b1;
    end else if (startCmd) begin
      done <= 1'b0;
    end
  end

  // pin latch; only the selected pin ever changes
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      pinOut <= `PPW_RST_PINS;
    end else begin
      pinOut <= next_pins;
    end
  end

  // read mux; data only in the cycle after the strobe, zero otherwise
  wire [31:0] statusWord = {hits, 3'h0, entryIdx, 5'h00,
                            state == ppw_pkg::PPW_SEEK_SECOND, done, !idle};
  wire [31:0] readMux =
      (regAddr == `PPW_ADDR_STATUS) ? statusWord :
      (regAddr == `PPW_ADDR_MASK)   ? {24'h00_0000, mask} :
      (regAddr == `PPW_ADDR_FIRST)  ? {24'h00_0000, firstPattern} :
      (regAddr == `PPW_ADDR_SECOND) ? {24'h00_0000, secondPattern} :
      (regAddr == `PPW_ADDR_REPEAT) ? {16'h0000, repeatCount} :
      (regAddr == `PPW_ADDR_COUNT)  ? {27'h000_0000, intervalCount} :
      (regAddr == `PPW_ADDR_INDEX)  ? {27'h000_0000, wrIndex} :
      (regAddr == `PPW_ADDR_PORT)   ? {24'h00_0000, portIn} : 32'h0000_0000;

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      regRdata <= 32'h0000_0000;
    end else begin
      regRdata <= regRead ? readMux : 32'h0000_0000;
    end
  end

  assign cmdBusy = !idle;
  assign cmdDone = done;

  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  logic [6:0] clksSincePass;
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      clksSincePass <= 7'h00;
    end else if (startWait || sample) begin
      clksSincePass <= startWait ? 7'h0A : 7'h00;  // start is not tick aligned: one tick credit
    end else if (clksSincePass != 7'h7F) begin
      clksSincePass <= clksSincePass + 7'h01;
    end
  end

  a_first_toggle: assert property (startLong |=> pinOut != $past(pinOut))
    else $error("long train start did not toggle the pin");
  a_entry_limit: assert property (intervalCount <= 5'h14 && entryIdx <= 5'h14)
    else $error("entry count above twenty");
  a_delay_span: assert property ((state == ppw_pkg::PPW_TRAIN && !$rose(cmdBusy))
      |-> target >= 18'h0_000D && target <= 18'h3_0208)
    else $error("interval outside the range of a legal entry");
  a_interval_end: assert property ((state == ppw_pkg::PPW_TRAIN && pinOut != $past(pinOut)
      && $past(state) == ppw_pkg::PPW_TRAIN) |-> $past(elapsed) + 18'h0_0001
      == $past(target))
    else $error("pin toggled before the interval elapsed");
  a_tick_spacing: assert property (instTick |=> !instTick [*8])
    else $error("instruction ticks closer than expected");
  a_pass_length: assert property (sample |-> clksSincePass
      >= (isDebounced ? 7'h3C : 7'h32))
    else $error("port sampled sooner than one pass");
  a_no_timeout: assert property ((state == ppw_pkg::PPW_SEEK_FIRST && !accept)
      |=> state == ppw_pkg::PPW_SEEK_FIRST)
    else $error("wait left without a match");
  a_two_step: assert property ((state == ppw_pkg::PPW_SEEK_FIRST && accept && isChange)
      |=> state == ppw_pkg::PPW_SEEK_SECOND && !done)
    else $error("transition did not move to the second step");
  a_miss_clears: assert property ((sample && !match) |=> hits == 16'h0000)
    else $error("mismatch did not restart the match run");
  a_done_holds: assert property ((done && !startCmd) |=> done)
    else $error("done dropped without a new command");

  c_train_done: cover property (state == ppw_pkg::PPW_TRAIN ##1 idle && done);
  c_change_done: cover property (state == ppw_pkg::PPW_SEEK_SECOND ##1 idle && done);
  c_run_broken: cover property (isDebounced && sample && !match && hits != 16'h0000);

endmodule

/* core/ppw_regs.svh */
/*
  Register offsets, field positions, reset values and timing counts of the
  port pulse and pattern wait block.
  Assumes a word-wide register port with a 4-bit word address.
*/
`ifndef PPW_REGS_SVH
`define PPW_REGS_SVH

// word addresses on the register port
`define PPW_ADDR_CMD        4'h0
`define PPW_ADDR_STATUS     4'h1
`define PPW_ADDR_MASK       4'h2
`define PPW_ADDR_FIRST      4'h3
`define PPW_ADDR_SECOND     4'h4
`define PPW_ADDR_REPEAT     4'h5
`define PPW_ADDR_COUNT      4'h6
`define PPW_ADDR_INDEX      4'h7
`define PPW_ADDR_DELAY      4'h8
`define PPW_ADDR_PORT       4'h9

// command word fields
`define PPW_CMD_PIN_LSB     0
`define PPW_CMD_PIN_MSB     2
`define PPW_CMD_KIND_LSB    3
`define PPW_CMD_KIND_MSB    4
`define PPW_CMD_DEBOUNCE    5
`define PPW_CMD_GO          7

// status word fields
`define PPW_STAT_BUSY       0
`define PPW_STAT_DONE       1
`define PPW_STAT_SECOND     2
`define PPW_STAT_IDX_LSB    8
`define PPW_STAT_IDX_MSB    12
`define PPW_STAT_HITS_LSB   16
`define PPW_STAT_HITS_MSB   31

// reset values
`define PPW_RST_MASK        8'hFF
`define PPW_RST_PATTERN     8'h00
`define PPW_RST_REPEAT      16'h0001
`define PPW_RST_COUNT       5'h00
`define PPW_RST_PINS        8'h00

// instruction rate derived from the system clock rate, both in MHz
`define PPW_CLK_RATE_MHZ    8'h7D
`define PPW_INST_RATE_MHZ   8'h0C

// timing in instruction cycles
`define PPW_FIXED_INST      18'h0_000A
`define PPW_INNER_INST      18'h0_0003
`define PPW_OUTER_INST      18'h0_0002
`define PPW_SAMPLE_INST     3'h5
`define PPW_DEBOUNCE_INST   3'h6

// limits of the long toggle train
`define PPW_MAX_ENTRIES     5'h14
`define PPW_MAX_DELAY       32'h0001_0000

`endif

/* core/ppw_pkg.sv */
/*
  Types of the port pulse and pattern wait block.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package ppw_pkg;

  // engine state; gray along idle->train->idle and first->second->idle, not idle->first
  typedef enum logic [1:0] {
    PPW_IDLE        = 2'h0,
    PPW_TRAIN       = 2'h1,
    PPW_SEEK_FIRST  = 2'h3,
    PPW_SEEK_SECOND = 2'h2
  } ppw_state_t;

  // command kind field
  typedef enum logic [1:0] {
    PPW_KIND_LONG_TRAIN    = 2'h0,
    PPW_KIND_AWAIT_PATTERN = 2'h1,
    PPW_KIND_AWAIT_CHANGE  = 2'h2,
    PPW_KIND_UNUSED        = 2'h3
  } ppw_kind_t;

endpackage

/* core/ppw_delay_mem.sv */
/*
  Small memory holding the delay entries of a long toggle train.
  Assumes one write port and one read address; read data are registered.
*/
module ppw_delay_mem (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        sys_rst,
  // write side
  input  wire logic        wrEn,
  input  wire logic [4:0]  wrAddr,
  input  wire logic [15:0] wrData,
  // read side
  input  wire logic [4:0]  rdAddr,
  output logic      [15:0] rdData
);

  logic [15:0] store [0:19];

  // cleared at reset so an unwritten entry reads as the shortest delay
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      for (int i = 0; i < 20; i++) begin
        store[i] <= 16'h0000;
      end
      rdData <= 16'h0000;
    end else begin
      if (wrEn && wrAddr < 5'h14) begin
        store[wrAddr] <= wrData;
      end
      rdData <= (rdAddr < 5'h14) ? store[rdAddr] : 16'h0000;
    end
  end

endmodule

/* testbench/ppw_pin_model.sv */
/*
  Far-side model of the port: drives the port pins and times pin toggles.
  Assumes the block's clock and reset; pins change only on rising edges.
*/
module ppw_pin_model #(
  parameter int HOLD_MIN = 53
) (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        sys_rst,
  // pins
  input  wire logic [7:0]  pinOut,
  input  wire logic [7:0]  wantPat,
  output logic      [7:0]  portIn,
  // toggle timing
  output logic      [15:0] gapClk,
  output logic      [7:0]  togCnt
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] heldFor;
  logic [15:0] sinceTog;
  logic [7:0]  prevPins;

  // pattern held long
  // a new pattern waits until the old one stood 54 clocks (432 ns), so none is too short
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      portIn  <= 8'h00;
      heldFor <= 16'h0000;
    end else if (wantPat != portIn && heldFor >= HOLD_MIN) begin
      portIn  <= wantPat;
      heldFor <= 16'h0000;
    end else if (heldFor != 16'hFFFF) begin
      heldFor <= heldFor + 16'h0001;
    end
  end

  // clocks between pin changes, as a scope would show them
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      prevPins <= 8'h00;
      sinceTog <= 16'h0000;
      gapClk   <= 16'h0000;
      togCnt   <= 8'h00;
    end else begin
      prevPins <= pinOut;
      sinceTog <= (pinOut != prevPins) ? 16'h0001 : sinceTog + 16'h0001;
      if (pinOut != prevPins) begin
        gapClk <= sinceTog;
        togCnt <= togCnt + 8'h01;
      end
    end
  end
endmodule

/* testbench/test_port_pulse_and_pattern_wait.sv */
/*
  Self-checking bench of the port pulse and pattern wait engine.
  Assumes the pin model on the port and a 125 MHz clock.
*/
`include "ppw_regs.svh"
module test_port_pulse_and_pattern_wait;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {
    logic [1:0]  kind;
    logic        deb;
    logic [7:0]  mask;
    logic [7:0]  first;
    logic [7:0]  second;
    logic [15:0] rep;
    logic [9:0]  hold;
    logic [31:0] seq;
    logic [3:0]  expDone;
  } ppw_row_t;
  // port steps read left to right, done flag expected after each step
  localparam ppw_row_t ROWS [5] = '{
    '{2'h1, 1'b0, 8'hF0, 8'hA0, 8'h00, 16'h0001, 10'd300, 32'h505A_A500, 4'h3},
    '{2'h1, 1'b0, 8'h03, 8'h03, 8'h00, 16'h0001, 10'd300, 32'h0102_0103, 4'h1},
    '{2'h2, 1'b0, 8'hFF, 8'h01, 8'h02, 16'h0001, 10'd300, 32'h0201_0702, 4'h1},
    '{2'h1, 1'b1, 8'hFF, 8'h3C, 8'h00, 16'h0005, 10'd200, 32'h3C00_3C3C, 4'h1},
    '{2'h2, 1'b1, 8'h0F, 8'h05, 8'h0A, 16'h0003, 10'd200, 32'h0AF5_25FA, 4'h1}};
  localparam int DLY [4] = '{1, 2, 256, 257};
  logic        clk;
  logic        sys_rst;
  logic [3:0]  regAddr;
  logic [31:0] regWdata;
  logic        regWrite;
  logic        regRead;
  logic [31:0] regRdata;
  logic [7:0]  portIn;
  logic [7:0]  pinOut;
  logic        cmdBusy;
  logic        cmdDone;
  logic [7:0]  wantPat;
  logic [15:0] gapClk;
  logic [7:0]  togCnt;
  logic [31:0] d;
  int          errTotal;
  int          compares;
  int          cyc;
  int          n;
  int          t;

  ppw_core uut (.clk(clk), .sys_rst(sys_rst), .regAddr(regAddr), .regWdata(regWdata),
    .regWrite(regWrite), .regRead(regRead), .regRdata(regRdata), .portIn(portIn),
    .pinOut(pinOut), .cmdBusy(cmdBusy), .cmdDone(cmdDone));
  ppw_pin_model pins (.clk(clk), .sys_rst(sys_rst), .pinOut(pinOut), .wantPat(wantPat),
    .portIn(portIn), .gapClk(gapClk), .togCnt(togCnt));

  // clock
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  // hang guard, well beyond the ~29k cycles the run needs
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 90000) begin
      errTotal++;
      testDone;
    end
  end

  // register port: one-cycle strobes, read data in the following cycle
  task automatic wr(input logic [3:0] a, input logic [31:0] v);
    @(posedge clk);
    regAddr  <= a;
    regWdata <= v;
    regWrite <= 1'b1;
    @(posedge clk);
    regWrite <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, output logic [31:0] v);
    @(posedge clk);
    regAddr <= a;
    regRead <= 1'b1;
    @(posedge clk);
    regRead <= 1'b0;
    #1 v = regRdata;
  endtask
  function automatic logic [31:0] cmdW(input logic [2:0] pin, input logic [1:0] kind,
                                       input logic deb);
    cmdW = 32'h0000_0000;
    cmdW[`PPW_CMD_PIN_MSB:`PPW_CMD_PIN_LSB] = pin;
    cmdW[`PPW_CMD_KIND_MSB:`PPW_CMD_KIND_LSB] = kind;
    cmdW[`PPW_CMD_DEBOUNCE] = deb;
    cmdW[`PPW_CMD_GO] = 1'b1;
  endfunction

  // waits are bounded; settled values are read 1 ns past the edge
  task automatic tick(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask
  task automatic waitDone(output int k);
    k = 0;
    while (cmdDone !== 1'b1 && k < 4000) begin
      tick(1);
      k++;
    end
  endtask
  task automatic waitTog(input logic [7:0] target);
    for (int k = 0; k < 9000 && togCnt !== target; k++) tick(1);
  endtask

  // compare tasks: exact value, and value inside a window
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      errTotal++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic chkIn(input string nm, input int lo, input int hi, input logic [15:0] g);
    compares++;
    if ((g >= lo && g <= hi) !== 1'b1) begin
      errTotal++;
      $display("MISMATCH %s expected %0d..%0d seen %0d", nm, lo, hi, g);
    end
  endtask

  task testDone;
    if (errTotal == 0 && compares > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  // main sequence
  initial begin
    {sys_rst, regAddr, regWdata, regWrite, regRead, wantPat} = {1'b1, 46'h0};
    {errTotal, compares, cyc} = {32'd0, 32'd0, 32'd0};
    repeat (2) @(posedge clk);
    sys_rst <= 1'b0;
    #1;
    chk("reset pins", 8'h00, {cmdBusy, cmdDone, pinOut});
    rd(`PPW_ADDR_MASK, d);
    chk("mask", `PPW_RST_MASK, d);
    rd(`PPW_ADDR_REPEAT, d);
    chk("repeat", `PPW_RST_REPEAT, d);
    rd(4'hF, d);
    chk("unmapped", 32'h0, d);
    tick(1);
    chk("rdata idle", 32'h0, regRdata);
    // twenty-one toggles when more than twenty entries are asked for
    wr(`PPW_ADDR_COUNT, 32'd25);
    wr(`PPW_ADDR_CMD, cmdW(3'd2, ppw_pkg::PPW_KIND_LONG_TRAIN, 1'b0));
    tick(1);
    chk("first toggle", 9'h104, {cmdBusy, pinOut});
    waitDone(n);
    tick(1);
    chk("toggles", 10'h015, {cmdBusy, togCnt});
    // interval lengths around the outer loop boundary, ticks of 125/12 clocks
    wr(`PPW_ADDR_INDEX, 32'd0);
    foreach (DLY[i]) wr(`PPW_ADDR_DELAY, DLY[i]);
    wr(`PPW_ADDR_COUNT, 32'd4);
    wr(`PPW_ADDR_CMD, cmdW(3'd6, ppw_pkg::PPW_KIND_LONG_TRAIN, 1'b0));
    tick(1);
    chk("pin six", 8'h44, pinOut);
    foreach (DLY[i]) begin
      waitTog(8'd23 + 8'(i));
      t = ((10 + 3 * DLY[i] + 2 * ((DLY[i] - 1) / 256)) * 125 + 6) / 12;
      chkIn("interval", t - 11, t + 11, gapClk);
    end
    tick(1);
    chk("train end", 10'h144, {cmdBusy, cmdDone, pinOut});
    // ordinary pattern waits
    foreach (ROWS[r]) begin
      wr(`PPW_ADDR_MASK, ROWS[r].mask);
      wr(`PPW_ADDR_FIRST, ROWS[r].first);
      wr(`PPW_ADDR_SECOND, ROWS[r].second);
      wr(`PPW_ADDR_REPEAT, ROWS[r].rep);
      wantPat <= ROWS[r].seq[31:24];
      tick(60);
      wr(`PPW_ADDR_CMD, cmdW(3'd0, ROWS[r].kind, ROWS[r].deb));
      for (int i = 0; i < 4; i++) begin
        wantPat <= ROWS[r].seq[31 - 8 * i -: 8];
        tick(ROWS[r].hold);
        chk("wait done", ROWS[r].expDone[3 - i], cmdDone);
      end
    end
    // kind three is ignored: nothing starts and done stays up
    wr(`PPW_ADDR_CMD, cmdW(3'd5, 2'h3, 1'b0));
    tick(1);
    chk("unused kind", 10'h144, {cmdBusy, cmdDone, pinOut});
    // refused writes while busy, no timeout, sampling pace
    wr(`PPW_ADDR_MASK, 32'h0000_00FF);
    wr(`PPW_ADDR_FIRST, 32'h0000_0033);
    wr(`PPW_ADDR_REPEAT, 32'h0000_0001);
    wantPat <= 8'h00;
    tick(60);
    wr(`PPW_ADDR_CMD, cmdW(3'd0, ppw_pkg::PPW_KIND_AWAIT_PATTERN, 1'b0));
    wr(`PPW_ADDR_MASK, 32'h0000_0000);
    wr(`PPW_ADDR_CMD, cmdW(3'd1, ppw_pkg::PPW_KIND_LONG_TRAIN, 1'b0));
    tick(3000);
    chk("still waiting", 10'h244, {cmdBusy, cmdDone, pinOut});
    rd(`PPW_ADDR_STATUS, d);
    chk("status", 32'h0000_0401, d);
    wantPat <= 8'h33;
    waitDone(n);
    chkIn("pass time", 1, 56, 16'(n));
    wr(`PPW_ADDR_REPEAT, 32'h0000_0004);
    wantPat <= 8'h00;
    tick(60);
    wr(`PPW_ADDR_CMD, cmdW(3'd0, ppw_pkg::PPW_KIND_AWAIT_PATTERN, 1'b1));
    tick(100);
    wantPat <= 8'h33;
    waitDone(n);
    chkIn("debounce time", 186, 256, 16'(n));
    rd(`PPW_ADDR_PORT, d);
    chk("port", 32'h0000_0033, d);
    // reset in mid-train
    wr(`PPW_ADDR_CMD, cmdW(3'd3, ppw_pkg::PPW_KIND_LONG_TRAIN, 1'b0));
    tick(200);
    @(posedge clk);
    sys_rst <= 1'b1;
    tick(2);
    chk("mid reset", 10'h000, {cmdBusy, cmdDone, pinOut});
    @(posedge clk);
    sys_rst <= 1'b0;
    rd(`PPW_ADDR_FIRST, d);
    chk("first after reset", `PPW_RST_PATTERN, d);
    tick(1);
    testDone;
  end
endmodule
